// ===== vat_consts.svh
// Behaviour
// - Pages are 1 kbyte or 4 kbytes, chosen by each entry's size flag.
// - Accept 32-bit virtual addresses; privileged space splits into five areas.
// - Both mapped privileged areas translate through the buffer; cacheable needs the entry's flag and control enable.
// - Fixed cached area: physical address is virtual with bit 31 cleared; cacheable when the control enable is set.
// - Fixed uncached area: bits 31 to 29 cleared; never cached.
// - Fixed areas bypass the buffer and never raise miss or translation errors.
// - Control area ranges E0000000-EFFFFFFF and F4000000-FBFFFFFF are reserved.
// - Control area routes cache arrays, buffer arrays and control registers by range.
// - Unprivileged code reaches only the lower 2-Gbyte user area, translated by page.
// - Unprivileged access at 80000000 or above is refused with an address error.
// - Top three physical address bits are ignored, so shadow addresses alias.
// - Mapped areas with translation on search the buffer; a hit returns page data.
// - No matching entry raises a miss so the instruction is executed again.
// - Translation off passes the virtual address through; low 29 bits significant.
// - Cache address array gets the physical address with its top three bits cleared.
// - A control bit selects single or multiple virtual mode; only comparison differs.
// - An 8-bit space identifier in the high entry register tags the running process.
// - In single mode the identifier gives protection, not translation selection.
// - Page access rights apply separately to privileged and unprivileged operation.
// - Privilege bit 0 means unprivileged, 1 privileged.
// - High entry register: page number 31:10, identifier 7:0, bits 9:8 read zero.
// - Bit 8 of the translation control register selects the virtual memory mode.
`ifndef VAT_CONSTS_SVH
`define VAT_CONSTS_SVH
`define VAT_OFF_PGHI 8'h00
`define VAT_OFF_TCTL 8'h04
`define VAT_OFF_CCTL 8'h08
`define VAT_OFF_ELOW 8'h0C
`define VAT_OFF_ELOAD 8'h10
`define VAT_OFF_STAT 8'h14
`define VAT_OFF_FADDR 8'h18
`define VAT_TCTL_EN 0
`define VAT_TCTL_SSS 8
`define VAT_CCTL_CE 0
`define VAT_CCTL_WT 1
`define VAT_ELOW_V 8
`define VAT_ELOW_PR_LO 5
`define VAT_ELOW_SZ 4
`define VAT_ELOW_C 3
`define VAT_ELOW_D 2
`define VAT_ELOW_SH 1
`define VAT_ELOAD_FLUSH 31
`define VAT_STAT_MISS 0
`define VAT_STAT_AERR 1
`define VAT_STAT_PERR 2
`define VAT_SEG_FCACHED 3'h4
`define VAT_SEG_FUNCACHED 3'h5
`define VAT_SEG_MHIGH 3'h6
`define VAT_SEG_CTRL 3'h7
`define VAT_SUB_CACHE 3'h0
`define VAT_SUB_TLB 3'h1
`define VAT_SUB_REGS_HI 2'h3
`define VAT_SHADOW_W 3
`define VAT_PG_SMALL 10
`define VAT_PG_LARGE 12
`define VAT_RST_ZERO 32'h0000_0000
`endif

// ===== vat_pkg.sv
package vat_pkg;
  typedef enum logic [4:0] {
    VAT_ROUTE_MEM = 5'h01,
    VAT_ROUTE_CACHE_ARR = 5'h02,
    VAT_ROUTE_TLB_ARR = 5'h04,
    VAT_ROUTE_CTRL_REG = 5'h08,
    VAT_ROUTE_RESERVED = 5'h10
  } vat_route_e;
  typedef struct packed {
    logic valid;
    logic [21:0] virtual_page_number;
    logic [7:0] asid;
    logic [21:0] ppn;
    logic [1:0] pr;
    logic sz;
    logic c;
    logic d;
    logic sh;
  } vat_entry_s;
  typedef struct packed {
    logic valid;
    logic [31:0] va;
    logic priv;
    logic write;
  } vat_req_s;
  typedef struct packed {
    logic valid;
    logic [31:0] pa;
    logic [31:0] cache_addr;
    logic cacheable;
    logic write_through;
    logic miss;
    logic addr_error;
    logic prot_error;
    vat_route_e route;
  } vat_resp_s;
endpackage

// ===== vat_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "vat_consts.svh"
module vat_top #(
  parameter int ENTRIES = 16,
  parameter int IDX_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire vat_pkg::vat_req_s cpu_req,
  output vat_pkg::vat_resp_s cpu_resp
);
  import vat_pkg::*;

  logic [21:0] vpn_reg;
  logic [7:0] asid_reg;
  logic trans_en_reg;
  logic single_space_select;
  logic cache_en_reg;
  logic write_thru_reg;
  logic [31:0] elow_reg;
  logic [2:0] stat_reg;
  logic [31:0] faddr_reg;
  vat_entry_s tlb_mem [ENTRIES];
  vat_resp_s resp_next;
  logic [31:0] rdata_next;
  logic map_err;
  logic apb_done;
  logic wr_en;
  logic [ENTRIES-1:0] hit_vec;
  logic hit;
  vat_entry_s hit_e;
  logic [2:0] seg;

  // One wait state keeps prdata and pready straight from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `VAT_RST_ZERO;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && map_err;
      prdata <= (psel && penable && !pready && !pwrite) ? rdata_next : `VAT_RST_ZERO;
    end
  end

  assign apb_done = psel && penable && pready;
  assign wr_en = apb_done && pwrite && !pslverr;

  always_comb
  begin
    map_err = 1'b0;
    rdata_next = `VAT_RST_ZERO;
    if (paddr[31:8] != 24'h00_0000 || paddr[1:0] != 2'h0)
    begin
      map_err = 1'b1;
    end
    else
    begin
      unique case (paddr[7:0])
        `VAT_OFF_PGHI:
        begin
          rdata_next = {vpn_reg, 2'b00, asid_reg};
        end
        `VAT_OFF_TCTL:
        begin
          rdata_next[`VAT_TCTL_EN] = trans_en_reg;
          rdata_next[`VAT_TCTL_SSS] = single_space_select;
        end
        `VAT_OFF_CCTL:
        begin
          rdata_next[`VAT_CCTL_CE] = cache_en_reg;
          rdata_next[`VAT_CCTL_WT] = write_thru_reg;
        end
        `VAT_OFF_ELOW:
        begin
          rdata_next = elow_reg;
        end
        `VAT_OFF_ELOAD:
        begin
          rdata_next = `VAT_RST_ZERO;
        end
        `VAT_OFF_STAT:
        begin
          rdata_next[2:0] = stat_reg;
        end
        `VAT_OFF_FADDR:
        begin
          rdata_next = faddr_reg;
        end
        default:
        begin
          map_err = 1'b1;
        end
      endcase
    end
  end

  // A fault reloads the page number so the handler sees it; hardware wins over software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vpn_reg <= 22'h00_0000;
      asid_reg <= 8'h00;
    end
    else
    begin
      if (wr_en && paddr[7:0] == `VAT_OFF_PGHI)
      begin
        asid_reg <= pwdata[7:0];
      end
      if (resp_next.miss || resp_next.addr_error || resp_next.prot_error)
      begin
        vpn_reg <= cpu_req.va[31:10];
      end
      else if (wr_en && paddr[7:0] == `VAT_OFF_PGHI)
      begin
        vpn_reg <= pwdata[31:10];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trans_en_reg <= 1'b0;
      single_space_select <= 1'b0;
    end
    else if (wr_en && paddr[7:0] == `VAT_OFF_TCTL)
    begin
      trans_en_reg <= pwdata[`VAT_TCTL_EN];
      single_space_select <= pwdata[`VAT_TCTL_SSS];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cache_en_reg <= 1'b0;
      write_thru_reg <= 1'b0;
    end
    else if (wr_en && paddr[7:0] == `VAT_OFF_CCTL)
    begin
      cache_en_reg <= pwdata[`VAT_CCTL_CE];
      write_thru_reg <= pwdata[`VAT_CCTL_WT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      elow_reg <= `VAT_RST_ZERO;
    end
    else if (wr_en && paddr[7:0] == `VAT_OFF_ELOW)
    begin
      elow_reg <= pwdata;
    end
  end

  // Sticky fault flags cleared by writing ones; a new fault in the same cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_reg <= 3'h0;
      faddr_reg <= `VAT_RST_ZERO;
    end
    else
    begin
      stat_reg <= (stat_reg & ~((wr_en && paddr[7:0] == `VAT_OFF_STAT) ? pwdata[2:0] : 3'h0))
                  | {resp_next.prot_error, resp_next.addr_error, resp_next.miss};
      if (resp_next.miss || resp_next.addr_error || resp_next.prot_error)
      begin
        faddr_reg <= cpu_req.va;
      end
    end
  end

  // Entries are loaded from the staged high and low registers; no range check on the
  // physical page, software must keep it in the lower half
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        tlb_mem[i] <= '0;
      end
    end
    else if (wr_en && paddr[7:0] == `VAT_OFF_ELOAD)
    begin
      if (pwdata[`VAT_ELOAD_FLUSH])
      begin
        for (int i = 0; i < ENTRIES; i++)
        begin
          tlb_mem[i].valid <= 1'b0;
        end
      end
      else
      begin
        tlb_mem[pwdata[IDX_W-1:0]] <= '{valid: elow_reg[`VAT_ELOW_V], virtual_page_number: vpn_reg, asid: asid_reg,
                                      ppn: elow_reg[31:10], pr: elow_reg[`VAT_ELOW_PR_LO +: 2],
                                      sz: elow_reg[`VAT_ELOW_SZ], c: elow_reg[`VAT_ELOW_C],
                                      d: elow_reg[`VAT_ELOW_D], sh: elow_reg[`VAT_ELOW_SH]};
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++)
    begin : g_cmp
      logic vpn_eq;
      logic asid_ok;
      // Large pages ignore the two low page-number bits
      assign vpn_eq = tlb_mem[g].sz ? (cpu_req.va[31:`VAT_PG_LARGE] == tlb_mem[g].virtual_page_number[21:2])
                                    : (cpu_req.va[31:`VAT_PG_SMALL] == tlb_mem[g].virtual_page_number);
      // Single mode matches on page only; identifier is checked later for protection
      assign asid_ok = single_space_select || tlb_mem[g].sh || (tlb_mem[g].asid == asid_reg);
      assign hit_vec[g] = tlb_mem[g].valid && vpn_eq && asid_ok;
    end
  endgenerate

  // Lowest index wins if software left duplicates
  always_comb
  begin
    hit_e = '0;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (hit_vec[i])
      begin
        hit_e = tlb_mem[i];
      end
    end
  end

  assign hit = |hit_vec;
  assign seg = cpu_req.va[31:29];

  always_comb
  begin
    resp_next = '0;
    resp_next.valid = cpu_req.valid;
    resp_next.route = VAT_ROUTE_MEM;
    resp_next.write_through = write_thru_reg;
    if (!cpu_req.priv && cpu_req.va[31])
    begin
      resp_next.addr_error = cpu_req.valid;
    end
    else if (seg == `VAT_SEG_FCACHED)
    begin
      resp_next.pa = {1'b0, cpu_req.va[30:0]};
      resp_next.cacheable = cache_en_reg;
    end
    else if (seg == `VAT_SEG_FUNCACHED)
    begin
      resp_next.pa = {3'b000, cpu_req.va[28:0]};
      resp_next.cacheable = 1'b0;
    end
    else if (seg == `VAT_SEG_CTRL)
    begin
      resp_next.pa = cpu_req.va;
      if (!cpu_req.va[28])
      begin
        resp_next.route = VAT_ROUTE_RESERVED;
      end
      else if (cpu_req.va[27:25] == `VAT_SUB_CACHE)
      begin
        resp_next.route = VAT_ROUTE_CACHE_ARR;
      end
      else if (cpu_req.va[27:25] == `VAT_SUB_TLB)
      begin
        resp_next.route = VAT_ROUTE_TLB_ARR;
      end
      else if (cpu_req.va[27:26] == `VAT_SUB_REGS_HI)
      begin
        resp_next.route = VAT_ROUTE_CTRL_REG;
      end
      else
      begin
        resp_next.route = VAT_ROUTE_RESERVED;
      end
    end
    else if (!trans_en_reg)
    begin
      resp_next.pa = cpu_req.va;
      resp_next.cacheable = cache_en_reg;
    end
    else if (!hit)
    begin
      resp_next.miss = cpu_req.valid;
    end
    else
    begin
      resp_next.pa = hit_e.sz ? {hit_e.ppn[21:2], cpu_req.va[11:0]}
                              : {hit_e.ppn, cpu_req.va[9:0]};
      resp_next.cacheable = cache_en_reg && hit_e.c;
      // Bit 1 grants unprivileged access, bit 0 grants writes
      resp_next.prot_error = cpu_req.valid && ((!cpu_req.priv && !hit_e.pr[1])
                             || (cpu_req.write && !hit_e.pr[0])
                             || (single_space_select && !hit_e.sh && hit_e.asid != asid_reg));
    end
    // Shadow bits dropped so all aliases share one cache line
    resp_next.cache_addr = {{`VAT_SHADOW_W{1'b0}}, resp_next.pa[28:0]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_resp <= '0;
    end
    else
    begin
      cpu_resp <= resp_next;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_fixed_cached;
    cpu_req.valid && cpu_req.priv && cpu_req.va[31:29] == `VAT_SEG_FCACHED
      |=> cpu_resp.valid && cpu_resp.pa == {1'b0, $past(cpu_req.va[30:0])} && !cpu_resp.miss;
  endproperty
  a_fixed_cached: assert property (p_fixed_cached) else $error("fixed cached map wrong");

  property p_fixed_uncached;
    cpu_req.valid && cpu_req.priv && cpu_req.va[31:29] == `VAT_SEG_FUNCACHED
      |=> !cpu_resp.cacheable && cpu_resp.pa[31:29] == 3'b000 && cpu_resp.pa[28:0] == $past(cpu_req.va[28:0]);
  endproperty
  a_fixed_uncached: assert property (p_fixed_uncached) else $error("fixed uncached map wrong");

  property p_fixed_nofault;
    cpu_req.valid && cpu_req.priv && (cpu_req.va[31:29] == `VAT_SEG_FCACHED || cpu_req.va[31:29] == `VAT_SEG_FUNCACHED)
      |=> !cpu_resp.miss && !cpu_resp.prot_error && !cpu_resp.addr_error;
  endproperty
  a_fixed_nofault: assert property (p_fixed_nofault) else $error("fixed area faulted");

  property p_user_err;
    cpu_req.valid && !cpu_req.priv && cpu_req.va[31] |=> cpu_resp.addr_error ##1 stat_reg[`VAT_STAT_AERR];
  endproperty
  a_user_err: assert property (p_user_err) else $error("user access not refused");

  property p_shadow;
    cpu_resp.valid |-> cpu_resp.cache_addr[31:29] == 3'b000 && cpu_resp.cache_addr[28:0] == cpu_resp.pa[28:0];
  endproperty
  a_shadow: assert property (p_shadow) else $error("cache address not masked");

  property p_bypass;
    cpu_req.valid && !trans_en_reg && !cpu_req.va[31] |=> cpu_resp.pa == $past(cpu_req.va) && !cpu_resp.miss;
  endproperty
  a_bypass: assert property (p_bypass) else $error("pass-through wrong");

  property p_miss;
    cpu_req.valid && trans_en_reg && !cpu_req.va[31] && !hit |=> cpu_resp.miss ##1 vpn_reg == $past(cpu_req.va[31:10], 2);
  endproperty
  a_miss: assert property (p_miss) else $error("miss not raised");

  property p_ctrl_route;
    cpu_req.valid && cpu_req.priv && cpu_req.va[31:26] == 6'h3F |=> cpu_resp.route == VAT_ROUTE_CTRL_REG;
  endproperty
  a_ctrl_route: assert property (p_ctrl_route) else $error("control route wrong");

  property p_reserved;
    cpu_req.valid && cpu_req.priv && cpu_req.va[31:28] == 4'hE |=> cpu_resp.route == VAT_ROUTE_RESERVED;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved route wrong");

  property p_apb_ready;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing wrong");

  c_hit: cover property (cpu_req.valid && trans_en_reg && hit && !cpu_req.va[31] ##1 !cpu_resp.prot_error);
  c_miss: cover property (cpu_resp.miss);
  c_user_err: cover property (cpu_resp.addr_error);
  c_prot: cover property (cpu_resp.prot_error);
endmodule
`default_nettype wire

// ===== vat_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module vat_cpu_model
(
  input wire logic pclk,
  input wire logic presetn,
  output vat_pkg::vat_req_s cpu_req,
  input wire vat_pkg::vat_resp_s cpu_resp
);
  import vat_pkg::*;

  initial cpu_req = '0;
  // Withdrawn request shows inverted lines so a stale address cannot pass for a held one
  task automatic access(input logic [31:0] va, input logic pv, input logic wr, output vat_resp_s r);
    @(posedge pclk);
    cpu_req <= '{valid: 1'b1, va: va, priv: pv, write: wr};
    @(posedge pclk);
    cpu_req <= '{valid: 1'b0, va: ~va, priv: ~pv, write: ~wr};
    #1;
    r = cpu_resp;
  endtask
endmodule
`default_nettype wire

// ===== test_virtual_address_map_and_tlb_lookup.sv
`timescale 1ns/1ns
`default_nettype none
`include "vat_consts.svh"
module test_virtual_address_map_and_tlb_lookup;
  import vat_pkg::*;
  localparam logic [31:0] A_PGHI = {24'h0, `VAT_OFF_PGHI};
  localparam logic [31:0] A_TCTL = {24'h0, `VAT_OFF_TCTL};
  localparam logic [31:0] A_CCTL = {24'h0, `VAT_OFF_CCTL};
  localparam logic [31:0] A_ELOW = {24'h0, `VAT_OFF_ELOW};
  localparam logic [31:0] A_ELOAD = {24'h0, `VAT_OFF_ELOAD};
  localparam logic [31:0] A_STAT = {24'h0, `VAT_OFF_STAT};
  localparam logic [31:0] A_FADR = {24'h0, `VAT_OFF_FADDR};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, q;
  vat_req_s cpu_req;
  vat_resp_s cpu_resp, r;
  int errors, n_tests, cyc;
  vat_top #(.ENTRIES(16), .IDX_W(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_req(cpu_req), .cpu_resp(cpu_resp)
  );
  vat_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .cpu_req(cpu_req), .cpu_resp(cpu_resp));
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic results();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready and read data are read as sampled at the edge that ends the access
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
      errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // Fault flags in order miss, address error, protection; address checked only without fault
  task automatic look(input logic [31:0] va, input logic pv, input logic wr, input logic [31:0] pa,
                      input logic [2:0] f);
    i_cpu.access(va, pv, wr, r);
    chk({28'h0, r.valid, r.miss, r.addr_error, r.prot_error}, {29'h1, f});
    if (f == 3'h0)
      chk(r.pa, pa);
  endtask
  task automatic ld(input logic [3:0] i, input logic [31:0] hi, input logic [31:0] lo);
    apb(1'b1, A_PGHI, hi);
    apb(1'b1, A_ELOW, lo);
    apb(1'b1, A_ELOAD, {28'h0, i});
  endtask
  task automatic t_regs();
    rdchk(A_TCTL, 32'h0);
    rdchk(A_STAT, 32'h0);
    apb(1'b1, A_PGHI, 32'hFFFF_FFFF);
    rdchk(A_PGHI, 32'hFFFF_FCFF);
    apb(1'b0, 32'h0000_0100, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
  endtask
  task automatic t_fixed();
    apb(1'b1, A_TCTL, 32'h1);
    apb(1'b1, A_CCTL, 32'h1);
    look(32'h8000_1000, 1'b1, 1'b0, 32'h0000_1000, 3'h0);
    chk({26'h0, r.cacheable, r.route}, {26'h0, 1'b1, VAT_ROUTE_MEM});
    chk(r.cache_addr, 32'h0000_1000);
    look(32'hA000_1000, 1'b1, 1'b1, 32'h0000_1000, 3'h0);
    chk({31'h0, r.cacheable}, 32'h0);
    look(32'hBFFF_FFFC, 1'b1, 1'b0, 32'h1FFF_FFFC, 3'h0);
  endtask
  task automatic t_ctrl();
    logic [31:0] va [7] = '{32'hE000_0000, 32'hEFFF_FFFC, 32'hF000_0000, 32'hF1FF_FFFC,
                            32'hF200_0000, 32'hF400_0000, 32'hFC00_0000};
    vat_route_e rt [7] = '{VAT_ROUTE_RESERVED, VAT_ROUTE_RESERVED, VAT_ROUTE_CACHE_ARR,
                           VAT_ROUTE_CACHE_ARR, VAT_ROUTE_TLB_ARR, VAT_ROUTE_RESERVED, VAT_ROUTE_CTRL_REG};
    for (int i = 0; i < 7; i++)
    begin
      look(va[i], 1'b1, 1'b0, va[i], 3'h0);
      chk({27'h0, r.route}, {27'h0, rt[i]});
    end
  endtask
  task automatic t_user();
    look(32'h8000_0000, 1'b0, 1'b0, 32'h0, 3'h2);
    look(32'hFFFF_FFFC, 1'b0, 1'b1, 32'h0, 3'h2);
    rdchk(A_FADR, 32'hFFFF_FFFC);
    look(32'h7FFF_FFFC, 1'b0, 1'b0, 32'h0, 3'h4);
    rdchk(A_STAT, 32'h3);
    rdchk(A_PGHI, 32'h7FFF_FCFF);
    apb(1'b1, A_STAT, 32'h7);
    rdchk(A_STAT, 32'h0);
    look(32'hC000_0000, 1'b1, 1'b0, 32'h0, 3'h4);
  endtask
  task automatic t_xlate();
    apb(1'b1, A_TCTL, 32'h0);
    look(32'hC000_1234, 1'b1, 1'b0, 32'hC000_1234, 3'h0);
    chk(r.cache_addr, 32'h0000_1234);
    apb(1'b1, A_TCTL, 32'h1);
    apb(1'b1, A_CCTL, 32'h3);
    // Every physical page stays in the lower half of the space
    ld(4'h0, 32'h0040_0405, 32'h1234_5D68);
    ld(4'h1, 32'h0040_2005, 32'h00AB_C178);
    ld(4'h2, 32'h0040_4005, 32'h0055_5150);
    ld(4'h3, 32'h0040_6005, 32'h0077_7162);
    look(32'h0040_0408, 1'b0, 1'b1, 32'h1234_5C08, 3'h0);
    chk({30'h0, r.cacheable, r.write_through}, 32'h3);
    look(32'h0040_0808, 1'b0, 1'b0, 32'h0, 3'h4);
    look(32'h0040_2FFC, 1'b0, 1'b0, 32'h00AB_CFFC, 3'h0);
    look(32'h0040_4010, 1'b0, 1'b0, 32'h0055_5010, 3'h0);
    chk({31'h0, r.cacheable}, 32'h0);
    look(32'h0040_4010, 1'b0, 1'b1, 32'h0, 3'h1);
    apb(1'b1, A_PGHI, 32'h0000_0006);
    look(32'h0040_0408, 1'b0, 1'b0, 32'h0, 3'h4);
    look(32'h0040_6004, 1'b0, 1'b0, 32'h0077_7004, 3'h0);
    apb(1'b1, A_TCTL, 32'h0000_0101);
    look(32'h0040_0408, 1'b0, 1'b0, 32'h0, 3'h1);
    rdchk(A_STAT, 32'h5);
    rdchk(A_FADR, 32'h0040_0408);
    apb(1'b1, A_ELOAD, 32'h8000_0000);
    look(32'h0040_6004, 1'b0, 1'b0, 32'h0, 3'h4);
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    errors = 0;
    n_tests = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fixed();
    t_ctrl();
    t_user();
    t_xlate();
    results();
  end
endmodule
`default_nettype wire
